// File: shared/pphp_cfg.svh
`ifndef PPHP_CFG_SVH
`define PPHP_CFG_SVH

// register word offsets on the avalon side (byte addresses, bit 17 clear)
`define PPHP_REG_CONFIG 17'h00000
`define PPHP_REG_STATUS 17'h00004
`define PPHP_REG_NRTSIZE 17'h00008
`define PPHP_REG_MARKER 17'h0000C
// avalon address bit that selects the shared memory window
`define PPHP_MEM_WINDOW_BIT 17

// config register field positions
`define PPHP_CFG_ENABLE 0
`define PPHP_CFG_BUS16 1
`define PPHP_CFG_DIRSTYLE 2
`define PPHP_CFG_RDYHIGH 3
`define PPHP_CFG_PAGE4K 4
`define PPHP_CFG_START 5

// status register field positions
`define PPHP_STS_LANEERR 0
`define PPHP_STS_HOSTBUSY 1
`define PPHP_STS_MARKBUSY 2

// reset values
`define PPHP_CONFIG_RESET 5'h00
`define PPHP_NRTSIZE_RESET 16'h0000
// pin order: csN, wr, rdN, lane1, lane2, seg[1:0], addr[13:0], data[15:0]
`define PPHP_PIN_RESET 37'h1C00000000

// test marker location as a halfword index (byte 0x8000)
`define PPHP_MARKER_HW_IDX 15'h4000
`define PPHP_MARKER_LAST 2'h3

// page bases in 4 Kbyte mode and the reachable non-realtime window
`define PPHP_PAGE4K_BASE0 16'h0000
`define PPHP_PAGE4K_BASE1 16'h1000
`define PPHP_PAGE4K_BASE2 16'h8000
`define PPHP_PAGE4K_BASE3 16'h9000
`define PPHP_NRT_WIN_LO 16'h8000
`define PPHP_NRT_WIN_HI 16'h9FFF

`endif

// File: shared/pphp_pkg.sv
package pphp_pkg;

	// host-side access sequencer
	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_RDATA,
		HOST_HOLD
	} pphp_host_e;

	// avalon slave answer phases
	typedef enum logic [1:0] {
		AV_IDLE,
		AV_FETCH,
		AV_ANSWER
	} pphp_av_e;

	typedef logic [15:0] pphp_half_t;

endpackage : pphp_pkg

// File: hdl/pphp_dual_mem.sv
`timescale 1ns/1ns
// two-port shared memory, halfword wide with per-byte write lanes
module pphp_dual_mem #(
	parameter int ADDR_W = 15,
	parameter int DEPTH = 32768
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] aAddr,
	input wire logic [1:0] aWe,
	input wire logic [15:0] aWdata,
	output logic [15:0] aRdata,
	input wire logic [ADDR_W-1:0] bAddr,
	input wire logic [1:0] bWe,
	input wire logic [15:0] bWdata,
	output logic [15:0] bRdata
);

	logic [15:0] aRdata_q;
	logic [15:0] bRdata_q;

	// one array per byte lane; port b is written last so it wins a collision
	for (genvar l = 0; l < 2; l++) begin : g_lane
		logic [7:0] laneMem [DEPTH];
		always_ff @(posedge clock) begin
			if (aWe[l]) begin
				laneMem[aAddr] <= aWdata[8*l +: 8];
			end
			if (bWe[l]) begin
				laneMem[bAddr] <= bWdata[8*l +: 8];
			end
		end
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				aRdata_q[8*l +: 8] <= 8'h00;
				bRdata_q[8*l +: 8] <= 8'h00;
			end else begin
				aRdata_q[8*l +: 8] <= laneMem[aAddr];
				bRdata_q[8*l +: 8] <= laneMem[bAddr];
			end
		end
	end

	assign aRdata = aRdata_q;
	assign bRdata = bRdata_q;

endmodule : pphp_dual_mem

// File: hdl/paged_parallel_host_port.sv
// Behaviour
// - data bus is 8 or 16 bits, fixed while the port is enabled
// - strobe style: separate read/write strobes or one direction line
// - ready output polarity selectable, active low or active high
// - separate style: both strobes low active; direction style: 0 write
// - memory bytes ordered as a 16-bit little-endian device
// - 16-bit bus: lanes 10 low byte, 01 high byte, 00 word, 11 illegal
// - 8-bit bus: only lanes 10 legal, any low address bits
// - illegal lane combination raises an error event
// - two segment inputs decode to page 0..3
// - page size is 16 Kbyte or 4 Kbyte only
// - 16 Kbyte pages: 14 address lines plus segment reach all 64 Kbyte
// - 4 Kbyte pages reach event unit, IO memory, window 0x8000..0x9FFF
// - marker value and area size written at 0x8000 and 0x8004 on start
// - only one host interface, parallel or serial, in use at a time
// - ready output drives one host only, no high-impedance state
`timescale 1ns/1ns
module paged_parallel_host_port #(
	parameter logic [31:0] MARKER_VALUE = 32'h5A5A_0001, // arbitrary value
	parameter int MEM_ADDR_W = 15
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [17:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic hostChipSelectN,
	input wire logic hostWriteStrobe,
	input wire logic hostReadStrobeN,
	input wire logic byteLaneSel1,
	input wire logic byteLaneSel2,
	input wire logic [13:0] hostAddressLines,
	input wire logic pageSelectLow,
	input wire logic pageSelectHigh,
	input wire logic [15:0] hostDataLinesIn,
	output logic [15:0] hostDataLinesOut,
	output logic hostDataLinesOe,
	output logic hostReadyOut,
	output logic hostErrorEvent
);

	`include "pphp_cfg.svh"

	localparam int PW = 37;
	// a literal cannot be bit-selected, so the pin idle levels get a name
	localparam logic [PW-1:0] PIN_RESET = `PPHP_PIN_RESET;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	logic [PW-1:0] pinRaw;
	logic [PW-1:0] pinStable;
	logic csN, wrS, rdN, lane1, lane2;
	logic [1:0] pageSel;
	logic [13:0] hostAddr;
	logic [15:0] hostDin;

	// every pin passes four flops; the last one moves once stages two and three agree
	assign pinRaw = {hostChipSelectN, hostWriteStrobe, hostReadStrobeN,
		byteLaneSel1, byteLaneSel2, pageSelectHigh, pageSelectLow,
		hostAddressLines, hostDataLinesIn};
	for (genvar i = 0; i < PW; i++) begin : g_sync
		logic s1_q, s2_q, s3_q, stable_q;
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				s1_q <= PIN_RESET[i];
				s2_q <= PIN_RESET[i];
				s3_q <= PIN_RESET[i];
				stable_q <= PIN_RESET[i];
			end else begin
				s1_q <= pinRaw[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					stable_q <= s3_q;
				end
			end
		end
		assign pinStable[i] = stable_q;
	end
	assign {csN, wrS, rdN, lane1, lane2, pageSel, hostAddr, hostDin} =
		pinStable;

	logic cfgEnable_q, cfgBus16_q, cfgDirStyle_q, cfgReadyHigh_q, cfgPage4k_q;
	logic [15:0] nrtSize_q;
	logic laneErrSeen_q;
	logic markBusy_q;
	logic [1:0] markCnt_q;
	pphp_pkg::pphp_host_e hostState_q;
	pphp_pkg::pphp_av_e avPhase_q;

	// access framing: chip select plus the style's strobes
	logic accessReq, isWrite, strobeEnd, hostStart;
	assign accessReq = cfgEnable_q && !csN &&
		(cfgDirStyle_q || !wrS || !rdN);
	assign isWrite = !wrS;
	assign strobeEnd = csN || (!cfgDirStyle_q && wrS && rdN);
	assign hostStart = (hostState_q == pphp_pkg::HOST_IDLE) && accessReq;

	// byte lane decode per bus width, low lane is the even byte
	logic [1:0] lanes;
	logic lanesLegal;
	always_comb begin
		lanes = 2'h0;
		lanesLegal = 1'b0;
		if (cfgBus16_q) begin
			case ({lane2, lane1})
				2'b10: begin
					lanes = 2'h1;
					lanesLegal = 1'b1;
				end
				2'b01: begin
					lanes = 2'h2;
					lanesLegal = 1'b1;
				end
				2'b00: begin
					lanes = 2'h3;
					lanesLegal = 1'b1;
				end
				default: begin
					lanes = 2'h0;
					lanesLegal = 1'b0;
				end
			endcase
		end else begin
			lanesLegal = lane2 && !lane1;
			lanes = hostAddr[0] ? 2'h2 : 2'h1;
		end
	end

	// page mapping; 4 Kbyte pages land on fixed bases
	logic [15:0] pageBase, hostByteAddr;
	always_comb begin
		case (pageSel)
			2'b00: pageBase = `PPHP_PAGE4K_BASE0;
			2'b01: pageBase = `PPHP_PAGE4K_BASE1;
			2'b10: pageBase = `PPHP_PAGE4K_BASE2;
			default: pageBase = `PPHP_PAGE4K_BASE3;
		endcase
		if (cfgPage4k_q) begin
			hostByteAddr = pageBase | {4'h0, hostAddr[11:0]};
		end else begin
			hostByteAddr = {pageSel, hostAddr};
		end
	end

	// host memory port; a refused lane pattern never writes
	logic [MEM_ADDR_W-1:0] memAddrA;
	logic [1:0] memWeA;
	logic [15:0] memWdataA, memRdataA;
	assign memAddrA = hostByteAddr[15:1];
	assign memWeA = (hostStart && lanesLegal && isWrite) ? lanes : 2'h0;
	assign memWdataA = cfgBus16_q ? hostDin : {hostDin[7:0], hostDin[7:0]};

	logic hostRdy_q, hostErr_q, hostOe_q, hostReady_q;
	logic [15:0] hostDout_q;
	logic [1:0] hostLanes_q;

	// host access sequencer; ready waits for the strobe to end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hostState_q <= pphp_pkg::HOST_IDLE;
			hostRdy_q <= 1'b0;
			hostErr_q <= 1'b0;
			hostOe_q <= 1'b0;
			hostDout_q <= 16'h0000;
			hostLanes_q <= 2'h0;
		end else begin
			hostErr_q <= 1'b0;
			case (hostState_q)
				pphp_pkg::HOST_IDLE: begin
					if (hostStart) begin
						hostLanes_q <= lanes;
						if (!lanesLegal) begin
							hostErr_q <= 1'b1;
							hostRdy_q <= 1'b1;
							hostState_q <= pphp_pkg::HOST_HOLD;
						end else if (isWrite) begin
							hostRdy_q <= 1'b1;
							hostState_q <= pphp_pkg::HOST_HOLD;
						end else begin
							hostState_q <= pphp_pkg::HOST_RDATA;
						end
					end
				end
				pphp_pkg::HOST_RDATA: begin
					// 8-bit bus returns the addressed byte on the low lines
					if (cfgBus16_q) begin
						hostDout_q <= memRdataA;
					end else if (hostLanes_q[1]) begin
						hostDout_q <= {8'h00, memRdataA[15:8]};
					end else begin
						hostDout_q <= {8'h00, memRdataA[7:0]};
					end
					hostOe_q <= 1'b1;
					hostRdy_q <= 1'b1;
					hostState_q <= pphp_pkg::HOST_HOLD;
				end
				pphp_pkg::HOST_HOLD: begin
					if (strobeEnd) begin
						hostOe_q <= 1'b0;
						hostRdy_q <= 1'b0;
						hostState_q <= pphp_pkg::HOST_IDLE;
					end
				end
				default: hostState_q <= pphp_pkg::HOST_IDLE;
			endcase
		end
	end

	// ready pin is always driven, so it can only serve one host
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hostReady_q <= 1'b1;
		end else begin
			hostReady_q <= cfgReadyHigh_q ? hostRdy_q : !hostRdy_q;
		end
	end

	// avalon decode
	logic avMem, avWriteNow, cfgWrite, stsWrite, markStart;
	logic [31:0] regRead, readdata_q;
	logic waitrequest_q;
	logic [MEM_ADDR_W-1:0] memAddrB;
	logic [1:0] memWeB;
	logic [15:0] memWdataB, memRdataB;
	assign avMem = address[`PPHP_MEM_WINDOW_BIT];
	assign avWriteNow = write && (avPhase_q == pphp_pkg::AV_ANSWER);
	assign cfgWrite = avWriteNow && !avMem && byteenable[0] &&
		(address[16:0] == `PPHP_REG_CONFIG);
	assign stsWrite = avWriteNow && !avMem && byteenable[0] &&
		(address[16:0] == `PPHP_REG_STATUS);
	assign markStart = cfgWrite && writedata[`PPHP_CFG_START] && !markBusy_q;

	// avalon answer: two wait cycles cover the registered memory read
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			avPhase_q <= pphp_pkg::AV_IDLE;
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h00000000;
		end else begin
			case (avPhase_q)
				pphp_pkg::AV_IDLE: begin
					if ((read || write) && !markBusy_q) begin
						avPhase_q <= pphp_pkg::AV_FETCH;
					end
				end
				pphp_pkg::AV_FETCH: begin
					readdata_q <= avMem ? {16'h0000, memRdataB} : regRead;
					waitrequest_q <= 1'b0;
					avPhase_q <= pphp_pkg::AV_ANSWER;
				end
				pphp_pkg::AV_ANSWER: begin
					waitrequest_q <= 1'b1;
					avPhase_q <= pphp_pkg::AV_IDLE;
				end
				default: avPhase_q <= pphp_pkg::AV_IDLE;
			endcase
		end
	end

	// register read mux, unmapped offsets read zero
	always_comb begin
		regRead = 32'h00000000;
		case (address[16:0])
			`PPHP_REG_CONFIG: begin
				regRead[`PPHP_CFG_ENABLE] = cfgEnable_q;
				regRead[`PPHP_CFG_BUS16] = cfgBus16_q;
				regRead[`PPHP_CFG_DIRSTYLE] = cfgDirStyle_q;
				regRead[`PPHP_CFG_RDYHIGH] = cfgReadyHigh_q;
				regRead[`PPHP_CFG_PAGE4K] = cfgPage4k_q;
			end
			`PPHP_REG_STATUS: begin
				regRead[`PPHP_STS_LANEERR] = laneErrSeen_q;
				regRead[`PPHP_STS_HOSTBUSY] = hostState_q != pphp_pkg::HOST_IDLE;
				regRead[`PPHP_STS_MARKBUSY] = markBusy_q;
			end
			`PPHP_REG_NRTSIZE: regRead = {16'h0000, nrtSize_q};
			`PPHP_REG_MARKER: regRead = MARKER_VALUE;
			default: regRead = 32'h00000000;
		endcase
	end

	// port mode is frozen while enabled so a host never sees it move
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			{cfgPage4k_q, cfgReadyHigh_q, cfgDirStyle_q, cfgBus16_q,
				cfgEnable_q} <= `PPHP_CONFIG_RESET;
			nrtSize_q <= `PPHP_NRTSIZE_RESET;
		end else begin
			if (cfgWrite) begin
				cfgEnable_q <= writedata[`PPHP_CFG_ENABLE];
				if (!cfgEnable_q) begin
					cfgBus16_q <= writedata[`PPHP_CFG_BUS16];
					cfgDirStyle_q <= writedata[`PPHP_CFG_DIRSTYLE];
					cfgReadyHigh_q <= writedata[`PPHP_CFG_RDYHIGH];
					cfgPage4k_q <= writedata[`PPHP_CFG_PAGE4K];
				end
			end
			if (avWriteNow && !avMem && byteenable[1:0] == 2'h3 &&
				address[16:0] == `PPHP_REG_NRTSIZE) begin
				nrtSize_q <= writedata[15:0];
			end
		end
	end

	// sticky lane error, write one to clear; a new error beats the clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			laneErrSeen_q <= 1'b0;
		end else if (hostErr_q) begin
			laneErrSeen_q <= 1'b1;
		end else if (stsWrite && writedata[`PPHP_STS_LANEERR]) begin
			laneErrSeen_q <= 1'b0;
		end
	end

	// test marker writer: four halfwords from 0x8000 on port b
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			markBusy_q <= 1'b0;
			markCnt_q <= 2'h0;
		end else if (markStart) begin
			markBusy_q <= 1'b1;
			markCnt_q <= 2'h0;
		end else if (markBusy_q) begin
			markCnt_q <= markCnt_q + 2'h1;
			if (markCnt_q == `PPHP_MARKER_LAST) begin
				markBusy_q <= 1'b0;
			end
		end
	end

	always_comb begin
		case (markCnt_q)
			2'h0: memWdataB = MARKER_VALUE[15:0];
			2'h1: memWdataB = MARKER_VALUE[31:16];
			2'h2: memWdataB = nrtSize_q;
			default: memWdataB = 16'h0000;
		endcase
		if (!markBusy_q) begin
			memWdataB = writedata[15:0];
		end
	end
	assign memAddrB = markBusy_q ? `PPHP_MARKER_HW_IDX + {13'h0000, markCnt_q} :
		address[16:2];
	assign memWeB = markBusy_q ? 2'h3 :
		(avWriteNow && avMem) ? byteenable[1:0] : 2'h0;

	pphp_dual_mem #(
		.ADDR_W(MEM_ADDR_W),
		.DEPTH(1 << MEM_ADDR_W)
	) u_mem (
		.clock(clock),
		.rstn(rstn),
		.aAddr(memAddrA),
		.aWe(memWeA),
		.aWdata(memWdataA),
		.aRdata(memRdataA),
		.bAddr(memAddrB),
		.bWe(memWeB),
		.bWdata(memWdataB),
		.bRdata(memRdataB)
	);

	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;
	assign hostDataLinesOut = hostDout_q;
	assign hostDataLinesOe = hostOe_q;
	assign hostReadyOut = hostReady_q;
	assign hostErrorEvent = hostErr_q;

	sequence s_readStart;
		hostStart && lanesLegal && !isWrite;
	endsequence
	sequence s_dataDriven;
		##2 (hostOe_q && hostRdy_q);
	endsequence
	sequence s_avRequest;
		avPhase_q == pphp_pkg::AV_IDLE && (read || write) && !markBusy_q;
	endsequence
	sequence s_avAnswer;
		waitrequest_q ##1 waitrequest_q ##1 !waitrequest_q ##1 waitrequest_q;
	endsequence

	a_read_drive: assert property (s_readStart |-> s_dataDriven)
		else $error("read data not driven two cycles after start");
	a_lane_error: assert property (hostStart && !lanesLegal |->
		memWeA == 2'h0 ##1 hostErrorEvent ##1 !hostErrorEvent)
		else $error("illegal lanes did not give a single error pulse");
	a_ready_level: assert property (
		hostState_q == pphp_pkg::HOST_IDLE &&
		$past(hostState_q) == pphp_pkg::HOST_IDLE &&
		$stable(cfgReadyHigh_q) |-> hostReadyOut == !cfgReadyHigh_q)
		else $error("idle ready level ignores polarity");
	a_cfg_locked: assert property (cfgEnable_q && $past(cfgEnable_q) |->
		$stable({cfgBus16_q, cfgDirStyle_q, cfgReadyHigh_q, cfgPage4k_q}))
		else $error("port mode changed while enabled");
	a_page_16k: assert property (hostStart && !cfgPage4k_q |->
		memAddrA == {pageSel, hostAddr[13:1]})
		else $error("16 Kbyte page address wrong");
	a_page_4k: assert property (hostStart && cfgPage4k_q |->
		hostByteAddr[11:0] == hostAddr[11:0] &&
		(hostByteAddr < `PPHP_PAGE4K_BASE2 ||
		(hostByteAddr >= `PPHP_NRT_WIN_LO && hostByteAddr <= `PPHP_NRT_WIN_HI)))
		else $error("4 Kbyte page outside reachable areas");
	a_dir_write: assert property (hostStart && cfgDirStyle_q &&
		lanesLegal && !wrS |-> memWeA == lanes)
		else $error("direction style write not committed");
	a_byte8_lane: assert property (hostStart && !cfgBus16_q &&
		lanesLegal |-> memWeA != 2'h3 && lanes[hostAddr[0]])
		else $error("8-bit access picked wrong lane");
	a_data_release: assert property (
		hostState_q == pphp_pkg::HOST_HOLD && strobeEnd |=>
		!hostOe_q && !hostRdy_q)
		else $error("data lines held after strobe end");
	a_marker_run: assert property (markStart |=>
		markBusy_q [*4] ##1 !markBusy_q)
		else $error("marker writer did not run four cycles");
	a_avalon_answer: assert property (s_avRequest |-> s_avAnswer)
		else $error("avalon answer not two cycles after request");

endmodule : paged_parallel_host_port

// File: test/pphp_host_model.sv
`timescale 1ns/1ns
// host processor on the parallel bus, one transfer per call of xfer
module pphp_host_model (
	input wire logic clock,
	input wire logic dirStyle,
	input wire logic rdyHigh,
	input wire logic bus16,
	input wire logic [15:0] devOut,
	input wire logic devOe,
	input wire logic devReady,
	output logic csN = 1'b1,
	output logic wrLine = 1'b1,
	output logic rdN = 1'b1,
	output logic sel1 = 1'b0,
	output logic sel2 = 1'b1,
	output logic [1:0] seg = 2'h0,
	output logic [13:0] addr = 14'h0000,
	output logic [15:0] dataWire,
	output logic rdValid = 1'b0,
	output logic [15:0] rdData = 16'h0000,
	output logic hostTimeout = 1'b0
);
	logic drive = 1'b0;
	logic [15:0] hData = 16'h0000;
	logic [15:0] lastQ = 16'h0000;
	// released lines flip every cycle so a stale value never reads as data
	assign dataWire = devOe ? devOut : (drive ? hData : ~lastQ);
	always @(posedge clock) lastQ <= dataWire;

	// ready input is used, so no fixed 260 ns wait is needed
	task automatic xfer(input logic wr, input logic [1:0] lanes,
		input logic [1:0] s, input logic [13:0] a, input logic [15:0] d);
		int n;
		@(posedge clock);
		csN <= 1'b0;
		wrLine <= !wr;
		rdN <= wr || dirStyle;
		{sel2, sel1} <= lanes;
		seg <= s;
		addr <= bus16 ? {a[13:1], 1'b0} : a;
		drive <= wr;
		hData <= d;
		// everything held until ready seen active
		for (n = 0; n < 60 && devReady !== rdyHigh; n++) @(posedge clock);
		rdData <= dataWire;
		rdValid <= !wr;
		csN <= 1'b1;
		wrLine <= 1'b1;
		rdN <= 1'b1;
		drive <= 1'b0;
		@(posedge clock);
		rdValid <= 1'b0;
		for (n = n; n < 60 && devReady === rdyHigh; n++) @(posedge clock);
		if (n >= 60) hostTimeout <= 1'b1;
	endtask : xfer
endmodule : pphp_host_model

// File: test/testbench.sv
`timescale 1ns/1ns
// avalon master and host model around the port, queued expectations
module testbench;
	localparam logic [31:0] MARK = 32'h5A5A_0001; // arbitrary value
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [17:0] address = 18'h00000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic waitrequest;
	logic csN, wrLine, rdN, sel1, sel2, rdValid, hostTimeout;
	logic devOe, devReady, errEvent;
	logic [1:0] seg;
	logic [13:0] hAddr;
	logic [15:0] dataWire, devOut, rdData;
	logic [15:0] lfsrQ = 16'h000A;
	logic dirStyle = 1'b0;
	logic rdyHigh = 1'b0;
	logic bus16 = 1'b0;
	logic [31:0] avExpQ[$];
	logic [31:0] avMaskQ[$];
	logic [15:0] hExpQ[$];
	int miscompares = 0;
	int samplesChecked = 0;
	int errCount = 0;

	initial begin
		forever #2 clock = ~clock;
	end

	paged_parallel_host_port #(.MARKER_VALUE(MARK)) i_dut (
		.clock(clock), .rstn(rstn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .waitrequest(waitrequest),
		.hostChipSelectN(csN), .hostWriteStrobe(wrLine),
		.hostReadStrobeN(rdN), .byteLaneSel1(sel1), .byteLaneSel2(sel2),
		.hostAddressLines(hAddr), .pageSelectLow(seg[0]),
		.pageSelectHigh(seg[1]), .hostDataLinesIn(dataWire),
		.hostDataLinesOut(devOut), .hostDataLinesOe(devOe),
		.hostReadyOut(devReady), .hostErrorEvent(errEvent)
	);

	// only the parallel host is ever attached
	pphp_host_model i_host (
		.clock(clock), .dirStyle(dirStyle), .rdyHigh(rdyHigh),
		.bus16(bus16), .devOut(devOut), .devOe(devOe),
		.devReady(devReady), .csN(csN), .wrLine(wrLine), .rdN(rdN),
		.sel1(sel1), .sel2(sel2), .seg(seg), .addr(hAddr),
		.dataWire(dataWire), .rdValid(rdValid), .rdData(rdData),
		.hostTimeout(hostTimeout)
	);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// halfword of a shared memory byte address, seen from avalon
	function automatic logic [17:0] avMem(input logic [15:0] b);
		return 18'h20000 + {1'b0, b[15:1], 2'b00};
	endfunction : avMem

	task automatic stopTest();
		if (miscompares == 0 && samplesChecked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stopTest

	task automatic cmpAv(input logic [31:0] g, input logic [31:0] e,
		input logic [31:0] m);
		samplesChecked++;
		if ((g & m) !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g & m, e);
		end
	endtask : cmpAv

	task automatic cmpHost(input logic [15:0] g, input logic [15:0] e);
		samplesChecked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmpHost

	// request held until waitrequest is sampled low
	task automatic avXfer(input logic wr, input logic [17:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) break;
		end
		read <= 1'b0;
		write <= 1'b0;
		if (n == 40) begin
			miscompares++;
			stopTest();
		end
	endtask : avXfer

	task automatic avRead(input logic [17:0] a, input logic [31:0] e,
		input logic [31:0] m);
		avExpQ.push_back(e);
		avMaskQ.push_back(m);
		avXfer(1'b0, a, 32'h00000000);
	endtask : avRead

	// results are taken off the queues as they appear at the ports
	always @(posedge clock) begin
		if (read === 1'b1 && waitrequest === 1'b0)
			cmpAv(readdata, avExpQ.pop_front(), avMaskQ.pop_front());
		if (rdValid === 1'b1) cmpHost(rdData, hExpQ.pop_front());
		if (errEvent === 1'b1) errCount++;
		if (hostTimeout === 1'b1) begin
			miscompares++;
			stopTest();
		end
	end

	initial begin
		logic [15:0] w, c, e;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		avRead(18'h00000, 32'h00000000, 32'h0000003F);
		avRead(18'h0000C, MARK, 32'hFFFFFFFF);
		avRead(18'h00010, 32'h00000000, 32'hFFFFFFFF);
		lfsrQ = lfsr(lfsrQ);
		w = lfsrQ;
		avXfer(1'b1, 18'h00008, {16'h0000, w});
		avXfer(1'b1, 18'h00000, 32'h00000020);
		avRead(18'h30000, {16'h0000, MARK[15:0]}, 32'hFFFF);
		avRead(18'h30004, {16'h0000, MARK[31:16]}, 32'hFFFF);
		avRead(18'h30008, {16'h0000, w}, 32'hFFFF);
		// 16-bit bus, separate strobes, ready active low, 16 Kbyte pages
		bus16 = 1'b1;
		avXfer(1'b1, 18'h00000, 32'h00000003);
		for (int p = 0; p < 4; p++) begin
			lfsrQ = lfsr(lfsrQ);
			i_host.xfer(1'b1, 2'b00, 2'(p), 14'h2468, lfsrQ);
			avRead(avMem({2'(p), 14'h2468}), {16'h0, lfsrQ}, 32'hFFFF);
		end
		w = lfsrQ;
		c = lfsr(w);
		e = lfsr(c);
		lfsrQ = e;
		i_host.xfer(1'b1, 2'b10, 2'h3, 14'h2468, c);
		avRead(avMem(16'hE468), {16'h0, w[15:8], c[7:0]}, 32'hFFFF);
		i_host.xfer(1'b1, 2'b01, 2'h3, 14'h2468, e);
		avRead(avMem(16'hE468), {16'h0, e[15:8], c[7:0]}, 32'hFFFF);
		i_host.xfer(1'b1, 2'b11, 2'h3, 14'h2468, ~c);
		avRead(avMem(16'hE468), {16'h0, e[15:8], c[7:0]}, 32'hFFFF);
		cmpAv(errCount, 32'h1, 32'hFFFFFFFF);
		avRead(18'h00004, 32'h1, 32'h1);
		avXfer(1'b1, 18'h00004, 32'h00000001);
		avRead(18'h00004, 32'h0, 32'h7);
		avXfer(1'b1, avMem(16'h0010), {16'h0000, w});
		hExpQ.push_back(w);
		i_host.xfer(1'b0, 2'b00, 2'h0, 14'h0010, 16'h0000);
		// 8-bit bus, direction line, ready active high, 4 Kbyte pages
		avXfer(1'b1, 18'h00000, 32'h00000000);
		avXfer(1'b1, 18'h00000, 32'h0000001C);
		avXfer(1'b1, 18'h00000, 32'h0000001D);
		dirStyle = 1'b1;
		rdyHigh = 1'b1;
		bus16 = 1'b0;
		avRead(18'h00000, 32'h1D, 32'h1F);
		i_host.xfer(1'b1, 2'b10, 2'h2, 14'h3123, c);
		avRead(avMem(16'h8123), {16'h0, c[7:0], 8'h00}, 32'hFF00);
		i_host.xfer(1'b1, 2'b10, 2'h3, 14'h0FFF, e);
		avRead(avMem(16'h9FFF), {16'h0, e[7:0], 8'h00}, 32'hFF00);
		avXfer(1'b1, avMem(16'h8122), {16'h0000, e});
		hExpQ.push_back({8'h00, e[7:0]});
		i_host.xfer(1'b0, 2'b10, 2'h2, 14'h0122, 16'h0000);
		hExpQ.push_back({8'h00, e[15:8]});
		i_host.xfer(1'b0, 2'b10, 2'h2, 14'h0123, 16'h0000);
		i_host.xfer(1'b1, 2'b00, 2'h2, 14'h0123, ~e);
		avRead(avMem(16'h8122), {16'h0, e}, 32'hFFFF);
		cmpAv(errCount, 32'h2, 32'hFFFFFFFF);
		stopTest();
	end
endmodule : testbench
